// *** bench/cmpr_regs_chk.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// port checker for the codec misc control registers
// ----------------------------------------------------------------------------
module cmpr_regs_chk
  import cmpr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic bus_err_seen_i,
  input wire logic left_dac_powered_down_i,
  input wire logic right_dac_powered_down_i,
  input wire logic left_hpf_use_prog_coef_o,
  input wire logic right_hpf_use_prog_coef_o,
  input wire logic adc_to_prog_filter_o,
  input wire logic bus_err_detect_en_o,
  input wire logic bus_err_recover_o,
  input wire logic first_left_plus_input_bypass_o,
  input wire logic first_left_minus_input_bypass_o,
  input wire logic second_left_plus_input_bypass_o,
  input wire logic second_left_minus_input_bypass_o,
  input wire logic first_right_plus_input_bypass_o,
  input wire logic second_right_plus_input_bypass_o,
  input wire logic [1:0] dac_current_boost_o,
  input wire logic active_page_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // request taken, and a lane-0 write into the paged map while page zero is up
  logic take;
  logic wr;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = take & wb_we_i & wb_sel_i[0] & ~wb_adr_i[9] & ~active_page_o;

  property p_ack; take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  property p_rsvd;
    take && !wb_we_i && !wb_adr_i[9] && wb_adr_i[8:2] >= CMPR_RSVD_FIRST_IDX |=> wb_dat_o == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_page;
    logic [7:0] v;
    (take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00, v = wb_dat_i[7:0])
      |-> ##2 active_page_o == v[0];
  endproperty
  a_page: assert property (p_page) else $error("page bit wrong");
  property p_coef;
    logic [7:0] v;
    (wr && wb_adr_i[8:2] == CMPR_ADC_PATH_IDX, v = wb_dat_i[7:0])
      |-> ##2 {left_hpf_use_prog_coef_o, right_hpf_use_prog_coef_o} == v[7:6];
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient select wrong");
  property p_det;
    logic [7:0] v;
    (wr && wb_adr_i[8:2] == CMPR_ADC_PATH_IDX, v = wb_dat_i[7:0])
      |-> ##2 bus_err_detect_en_o == !v[2];
  endproperty
  a_det: assert property (p_det) else $error("detect enable wrong");
  property p_byp;
    logic [7:0] v;
    (wr && wb_adr_i[8:2] == CMPR_BYPASS_IDX, v = wb_dat_i[7:0])
      |-> ##2 {second_right_plus_input_bypass_o, first_right_plus_input_bypass_o,
      second_left_minus_input_bypass_o, second_left_plus_input_bypass_o,
      first_left_minus_input_bypass_o, first_left_plus_input_bypass_o} == {v[6], v[4], v[3:0]};
  endproperty
  a_byp: assert property (p_byp) else $error("bypass switch wrong");
  property p_dac;
    logic [7:0] v;
    (wr && wb_adr_i[8:2] == CMPR_DAC_CUR_IDX, v = wb_dat_i[7:0])
      |-> ##2 dac_current_boost_o == ((v[7:6] == 2'h2) ? 2'h0 : v[7:6]);
  endproperty
  a_dac: assert property (p_dac) else $error("dac current code wrong");
  property p_filt;
    adc_to_prog_filter_o |-> $past(left_dac_powered_down_i) && $past(right_dac_powered_down_i);
  endproperty
  a_filt: assert property (p_filt) else $error("filter joined with a dac up");
  property p_rec;
    bus_err_seen_i && bus_err_detect_en_o && $past(bus_err_detect_en_o) && !$past(wr)
      |-> ##[1:2] bus_err_recover_o;
  endproperty
  a_rec: assert property (p_rec) else $error("no recovery after error");
  property p_rec_cause;
    bus_err_recover_o |-> $past(bus_err_seen_i) || $past(bus_err_seen_i, 2);
  endproperty
  a_rec_cause: assert property (p_rec_cause) else $error("recovery without error");

  c_byp: cover property (wr ##2 second_right_plus_input_bypass_o);
  c_rec: cover property (bus_err_recover_o);
  c_irq: cover property (irq_o);
endmodule : cmpr_regs_chk

bind cmpr_regs cmpr_regs_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .bus_err_seen_i(bus_err_seen_i), .left_dac_powered_down_i(left_dac_powered_down_i),
  .right_dac_powered_down_i(right_dac_powered_down_i),
  .left_hpf_use_prog_coef_o(left_hpf_use_prog_coef_o),
  .right_hpf_use_prog_coef_o(right_hpf_use_prog_coef_o),
  .adc_to_prog_filter_o(adc_to_prog_filter_o), .bus_err_detect_en_o(bus_err_detect_en_o),
  .bus_err_recover_o(bus_err_recover_o),
  .first_left_plus_input_bypass_o(first_left_plus_input_bypass_o),
  .first_left_minus_input_bypass_o(first_left_minus_input_bypass_o),
  .second_left_plus_input_bypass_o(second_left_plus_input_bypass_o),
  .second_left_minus_input_bypass_o(second_left_minus_input_bypass_o),
  .first_right_plus_input_bypass_o(first_right_plus_input_bypass_o),
  .second_right_plus_input_bypass_o(second_right_plus_input_bypass_o),
  .dac_current_boost_o(dac_current_boost_o), .active_page_o(active_page_o), .irq_o(irq_o));

// *** bench/codec_misc_control_page_regs_test.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// self-checking bench with a register model kept in integers
// ----------------------------------------------------------------------------
module codec_misc_control_page_regs_test;
  import cmpr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:2] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic bus_err_seen_i = 1'b0;
  logic ldn_i = 1'b0;
  logic rdn_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [12:0] pins;
  logic irq_o;
  logic recover;
  int err_count = 0;
  int checked = 0;
  int r107 = 0, r108 = 0, r109 = 0, page = 0, flag = 0, stat = 0, mask = 0;
  logic [7:0] rst_idx [6] = '{8'h6B, 8'h6C, 8'h6D, 8'h00, 8'h80, 8'h81};

  always #4 clk_i = ~clk_i;

  cmpr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_err_seen_i(bus_err_seen_i),
    .left_dac_powered_down_i(ldn_i), .right_dac_powered_down_i(rdn_i),
    .left_hpf_use_prog_coef_o(pins[12]), .right_hpf_use_prog_coef_o(pins[11]),
    .adc_to_prog_filter_o(pins[10]), .bus_err_detect_en_o(pins[9]),
    .bus_err_recover_o(recover), .second_right_plus_input_bypass_o(pins[8]),
    .first_right_plus_input_bypass_o(pins[7]), .second_left_minus_input_bypass_o(pins[6]),
    .second_left_plus_input_bypass_o(pins[5]), .first_left_minus_input_bypass_o(pins[4]),
    .first_left_plus_input_bypass_o(pins[3]), .dac_current_boost_o(pins[2:1]),
    .active_page_o(pins[0]), .irq_o(irq_o));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t read data %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_pin(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t pins %h expected %h", $time, got, exp);
    end
  endtask : chk_pin

  // model read view; page one shows only the page register and the local block
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a[7]) v = (a[6:0] == CMPR_IRQ_STAT_IDX) ? 32'(stat) : (a[6:0] == 7'h01) ? 32'(mask) : 32'h0;
    else if (a[6:0] == CMPR_PAGE_SEL_IDX) v = 32'(page);
    else if (page == 0 && a[6:0] == CMPR_ADC_PATH_IDX) v = 32'((r107 & 8'hFC) | flag);
    else if (page == 0 && a[6:0] == CMPR_BYPASS_IDX) v = 32'(r108);
    else if (page == 0 && a[6:0] == CMPR_DAC_CUR_IDX) v = 32'(r109);
    return v;
  endfunction : exp_rd

  // model pin view; the reserved dac code drives as default
  function automatic logic [12:0] exp_pins();
    logic [1:0] d;
    d = 2'(r109 >> 6);
    if (d == CMPR_DAC_CUR_RESERVED) d = CMPR_DAC_CUR_DEFAULT;
    return {r107[7], r107[6], r107[3] & ldn_i & rdn_i, ~r107[2], r108[6], r108[4],
      r108[3:0], d, page[0]};
  endfunction : exp_pins

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] sel, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel;
    wb_dat_i <= {24'($urandom), d};
    n = 0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      end_sim();
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] sel);
    logic [31:0] rd;
    wb(1'b1, a, d, sel, rd);
    if (!sel[0]) return;
    if (a == 8'h81) mask = d[1:0];
    else if (a == 8'h00) page = d[0];
    else if (page == 0 && a == 8'h6B) r107 = d & 8'hFC;
    else if (page == 0 && a == 8'h6D) r109 = d;
    else if (page == 0 && a == 8'h6C)
    begin
      r108 = d;
      if ((d & 8'h05) == 8'h05 || (d & 8'h0A) == 8'h0A || (d & 8'h50) == 8'h50) stat |= 2;
    end
  endtask : wr

  // read, compare against the model, then apply clear-on-read
  task automatic rdc(input logic [7:0] a);
    logic [31:0] rd;
    wb(1'b0, a, 8'h00, 4'hF, rd);
    chk_rd(rd, exp_rd(a));
    if (a == 8'h80) stat = 0;
    if (page == 0 && a == 8'h6B) flag = 0;
  endtask : rdc

  task automatic pin_chk();
    repeat (2) @(negedge clk_i);
    chk_pin(pins, exp_pins());
  endtask : pin_chk

  task automatic irq_chk();
    repeat (3) @(negedge clk_i);
    chk_pin(13'(irq_o), 13'((stat & mask) != 0));
  endtask : irq_chk

  // one error pulse; recovery expected only with detection enabled
  task automatic bus_err();
    int hit;
    @(posedge clk_i);
    bus_err_seen_i <= 1'b1;
    @(posedge clk_i);
    bus_err_seen_i <= 1'b0;
    hit = 0;
    repeat (4)
    begin
      @(negedge clk_i);
      if (recover === 1'b1) hit = 1;
    end
    if (!r107[2]) {flag[0], stat[0]} = 2'b11;
    chk_pin(13'(hit), 13'(!r107[2]));
  endtask : bus_err

  initial
  begin
    void'($urandom(14));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    pin_chk();
    foreach (rst_idx[i]) rdc(rst_idx[i]);
    $display("test reset values done");
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk_i);
      ldn_i <= 1'($urandom);
      rdn_i <= 1'($urandom);
      wr(8'h6B, 8'($urandom) & 8'hCC, 4'hF);
      wr(8'h6C, 8'($urandom) & (i[0] ? 8'h4C : 8'h13), 4'hF);
      wr(8'h6D, 8'(((($urandom % 3) * 3) >> 1) << 6), 4'hF);
      pin_chk();
      rdc(8'h6B);
      rdc(8'h6C);
      rdc(8'h6D);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h6D, {2'(k | k >> 1), 6'h00}, 4'hF);
      pin_chk();
    end
    $display("test fields done");
    for (int a = 8'h6E; a <= 8'h7F; a++)
    begin
      rdc(8'(a));
    end
    wr(8'h6C, 8'hFF, 4'h0);
    rdc(8'h6C);
    $display("test reserved done");
    wr(8'h00, 8'h01, 4'hF);
    pin_chk();
    rdc(8'h00);
    rdc(8'h6B);
    wr(8'h6C, 8'h40, 4'hF);
    wr(8'h00, 8'h00, 4'hF);
    rdc(8'h00);
    rdc(8'h6C);
    $display("test page done");
    wr(8'h6B, 8'h00, 4'hF);
    wr(8'h81, 8'h01, 4'hF);
    rdc(8'h80);
    bus_err();
    irq_chk();
    rdc(8'h6B);
    rdc(8'h6B);
    irq_chk();
    rdc(8'h80);
    irq_chk();
    wr(8'h6B, 8'h04, 4'hF);
    bus_err();
    rdc(8'h6B);
    wr(8'h81, 8'h02, 4'hF);
    wr(8'h6C, 8'h05, 4'hF);
    irq_chk();
    wr(8'h81, 8'h00, 4'hF);
    irq_chk();
    rdc(8'h80);
    $display("test bus error done");
    end_sim();
  end
endmodule : codec_misc_control_page_regs_test

// *** inc/cmpr_pkg.sv ***
// ----------------------------------------------------------------------------
// codec misc control page register constants
// ----------------------------------------------------------------------------
package cmpr_pkg;

  // register index width; byte address on the bus is four times the index
  localparam int unsigned CMPR_IDX_W = 7;

  // ----------------------------------------------------------------------------
  // register indices; page select on either page, the rest only while page zero is active
  // ----------------------------------------------------------------------------
  localparam logic [6:0] CMPR_PAGE_SEL_IDX = 7'h00;
  localparam logic [6:0] CMPR_ADC_PATH_IDX = 7'h6B;
  localparam logic [6:0] CMPR_BYPASS_IDX = 7'h6C;
  localparam logic [6:0] CMPR_DAC_CUR_IDX = 7'h6D;
  localparam logic [6:0] CMPR_RSVD_FIRST_IDX = 7'h6E;
  localparam logic [6:0] CMPR_RSVD_LAST_IDX = 7'h7F;

  // local block, selected by the top address bit, outside the paged map
  localparam logic [6:0] CMPR_IRQ_STAT_IDX = 7'h00;
  localparam logic [6:0] CMPR_IRQ_MASK_IDX = 7'h01;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int unsigned CMPR_LEFT_COEF_BIT = 7;
  localparam int unsigned CMPR_RIGHT_COEF_BIT = 6;
  localparam int unsigned CMPR_RSVD54_LSB = 4;
  localparam int unsigned CMPR_FILT_PATH_BIT = 3;
  localparam int unsigned CMPR_DET_DIS_BIT = 2;
  localparam int unsigned CMPR_BUS_ERR_BIT = 0;
  localparam int unsigned CMPR_DAC_CUR_LSB = 6;
  localparam int unsigned CMPR_PAGE_BIT = 0;

  // bypass switch bit positions
  localparam int unsigned CMPR_BYP_L1P_BIT = 0;
  localparam int unsigned CMPR_BYP_L1M_BIT = 1;
  localparam int unsigned CMPR_BYP_L2P_BIT = 2;
  localparam int unsigned CMPR_BYP_L2M_BIT = 3;
  localparam int unsigned CMPR_BYP_R1P_BIT = 4;
  localparam int unsigned CMPR_BYP_R2P_BIT = 6;

  // ----------------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------------
  localparam logic [7:0] CMPR_ADC_PATH_RST = 8'h00;
  localparam logic [7:0] CMPR_BYPASS_RST = 8'h00;
  localparam logic [7:0] CMPR_DAC_CUR_RST = 8'h00;
  localparam logic CMPR_PAGE_RST = 1'b0;
  localparam logic [1:0] CMPR_IRQ_MASK_RST = 2'h0;
  localparam logic [7:0] CMPR_RSVD_READ = 8'h00;

  // dac reference current codes
  localparam logic [1:0] CMPR_DAC_CUR_DEFAULT = 2'h0;
  localparam logic [1:0] CMPR_DAC_CUR_PLUS50 = 2'h1;
  localparam logic [1:0] CMPR_DAC_CUR_RESERVED = 2'h2;
  localparam logic [1:0] CMPR_DAC_CUR_PLUS100 = 2'h3;

  // interrupt event bits
  localparam int unsigned CMPR_EVT_W = 2;
  localparam int unsigned CMPR_EVT_BUS_ERR = 0;
  localparam int unsigned CMPR_EVT_BYP_SHORT = 1;

endpackage : cmpr_pkg

// *** verilog/cmpr_regs.sv ***
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
// Behaviour
// - left coefficient bit: 0 default high-pass coefficients, 1 programmable ones
// - right coefficient bit: 0 default high-pass coefficients, 1 programmable ones
// - filter-path bit joins programmable filter to adc only with both dacs down
// - detect-disable bit 0 enables bus error detection and recovery; 1 disables
// - bus error flag set on detected error, cleared by reading its register
// - left bypass bits close switches from line inputs to left outputs
// - right bypass bits close switches from line inputs to right plus output
// - dac current code 00 default, 01 plus half, 11 double, 10 reserved
// - reserved page zero range reads zero; host never writes there
// - page bit 0 selects page zero, 1 selects page one for later accesses
// - page select register answers at index zero on either page
module cmpr_regs
  import cmpr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // surrounding codec logic
  input wire logic bus_err_seen_i,
  input wire logic left_dac_powered_down_i,
  input wire logic right_dac_powered_down_i,
  // controls to filter datapath and analog switches
  output logic left_hpf_use_prog_coef_o,
  output logic right_hpf_use_prog_coef_o,
  output logic adc_to_prog_filter_o,
  output logic bus_err_detect_en_o,
  output logic bus_err_recover_o,
  output logic first_left_plus_input_bypass_o,
  output logic first_left_minus_input_bypass_o,
  output logic second_left_plus_input_bypass_o,
  output logic second_left_minus_input_bypass_o,
  output logic first_right_plus_input_bypass_o,
  output logic second_right_plus_input_bypass_o,
  output logic [1:0] dac_current_boost_o,
  output logic active_page_o,
  output logic irq_o
);

  // ----------------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdata_q;
  logic access;
  logic wr_stb;
  logic rd_stb;
  logic [6:0] idx;
  logic local_sel;

  // a request is served exactly once, in the cycle before ack rises
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_stb = access && wb_we_i && wb_sel_i[0];
  assign rd_stb = access && !wb_we_i;
  assign idx = wb_adr_i[8:2];
  assign local_sel = wb_adr_i[9];

  // ----------------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------------
  logic [7:0] adc_path_q;
  logic [7:0] bypass_q;
  logic [7:0] dac_cur_q;
  logic page_q;
  logic [CMPR_EVT_W-1:0] irq_mask_q;
  logic [CMPR_EVT_W-1:0] irq_stat;
  logic bus_err_flag;

  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------
  logic hit_page;
  logic hit_adc;
  logic hit_byp;
  logic hit_dac;
  logic hit_rsvd;
  logic hit_stat;
  logic hit_mask;

  // paged registers only on page zero; page register on both pages
  always_comb
  begin
    hit_page = 1'b0;
    hit_adc = 1'b0;
    hit_byp = 1'b0;
    hit_dac = 1'b0;
    hit_rsvd = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    if (local_sel)
    begin
      if (idx == CMPR_IRQ_STAT_IDX)
      begin
        hit_stat = 1'b1;
      end
      else if (idx == CMPR_IRQ_MASK_IDX)
      begin
        hit_mask = 1'b1;
      end
    end
    else if (idx == CMPR_PAGE_SEL_IDX)
    begin
      hit_page = 1'b1;
    end
    else if (page_q)
    begin
      // page one coefficients live in another block: read as zero here
      hit_page = 1'b0;
    end
    else if (idx == CMPR_ADC_PATH_IDX)
    begin
      hit_adc = 1'b1;
    end
    else if (idx == CMPR_BYPASS_IDX)
    begin
      hit_byp = 1'b1;
    end
    else if (idx == CMPR_DAC_CUR_IDX)
    begin
      hit_dac = 1'b1;
    end
    else if (idx >= CMPR_RSVD_FIRST_IDX && idx <= CMPR_RSVD_LAST_IDX)
    begin
      hit_rsvd = 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // adc path and bus condition register
  // ----------------------------------------------------------------------------
  // zero after reset
  // bits 1 and 0 are never stored: bit 1 reads zero, bit 0 is the live flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      adc_path_q <= CMPR_ADC_PATH_RST;
    end
    else if (wr_stb && hit_adc)
    begin
      // reserved bits 5..4 are kept as written; host should keep them zero
      adc_path_q <= {wb_dat_i[7:2], 2'b00};
    end
  end

  // ----------------------------------------------------------------------------
  // bus error detection
  // ----------------------------------------------------------------------------
  logic det_en;
  logic err_event;

  // detection enabled while bit is zero
  assign det_en = !adc_path_q[CMPR_DET_DIS_BIT];
  assign err_event = bus_err_seen_i && det_en;

  cmpr_sticky #(
    .WIDTH(1)
  ) u_err_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(err_event),
    .clr_i(rd_stb && hit_adc),
    .flags_o(bus_err_flag)
  );

  // detector enable and recovery pulse, one cycle after each detected error cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_err_detect_en_o <= 1'b1;
      bus_err_recover_o <= 1'b0;
    end
    else
    begin
      bus_err_detect_en_o <= det_en;
      bus_err_recover_o <= err_event;
    end
  end

  // ----------------------------------------------------------------------------
  // adc filter selection outputs
  // ----------------------------------------------------------------------------
  // coefficient choice matters only while the high-pass is on; the filter
  // block applies that gate, so the bits are passed as stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      left_hpf_use_prog_coef_o <= 1'b0;
      right_hpf_use_prog_coef_o <= 1'b0;
      adc_to_prog_filter_o <= 1'b0;
    end
    else
    begin
      left_hpf_use_prog_coef_o <= adc_path_q[CMPR_LEFT_COEF_BIT];
      right_hpf_use_prog_coef_o <= adc_path_q[CMPR_RIGHT_COEF_BIT];
      // filter only with both dacs down
      adc_to_prog_filter_o <= adc_path_q[CMPR_FILT_PATH_BIT] &&
                              left_dac_powered_down_i && right_dac_powered_down_i;
    end
  end

  // ----------------------------------------------------------------------------
  // passive bypass switches
  // ----------------------------------------------------------------------------
  logic byp_short;

  // whole byte stored, reserved bits 7 and 5 included
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bypass_q <= CMPR_BYPASS_RST;
    end
    else if (wr_stb && hit_byp)
    begin
      bypass_q <= wb_dat_i[7:0];
    end
  end

  // the switches still close as asked; a short only raises an event since
  // the analog side cannot be protected from here
  // flag shorted input pairs
  assign byp_short = wr_stb && hit_byp &&
                     ((wb_dat_i[CMPR_BYP_L1P_BIT] && wb_dat_i[CMPR_BYP_L2P_BIT]) ||
                      (wb_dat_i[CMPR_BYP_L1M_BIT] && wb_dat_i[CMPR_BYP_L2M_BIT]) ||
                      (wb_dat_i[CMPR_BYP_R1P_BIT] && wb_dat_i[CMPR_BYP_R2P_BIT]));

  // switch drives, one flop each
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      first_left_plus_input_bypass_o <= 1'b0;
      first_left_minus_input_bypass_o <= 1'b0;
      second_left_plus_input_bypass_o <= 1'b0;
      second_left_minus_input_bypass_o <= 1'b0;
      first_right_plus_input_bypass_o <= 1'b0;
      second_right_plus_input_bypass_o <= 1'b0;
    end
    else
    begin
      first_left_plus_input_bypass_o <= bypass_q[CMPR_BYP_L1P_BIT];
      first_left_minus_input_bypass_o <= bypass_q[CMPR_BYP_L1M_BIT];
      second_left_plus_input_bypass_o <= bypass_q[CMPR_BYP_L2P_BIT];
      second_left_minus_input_bypass_o <= bypass_q[CMPR_BYP_L2M_BIT];
      first_right_plus_input_bypass_o <= bypass_q[CMPR_BYP_R1P_BIT];
      second_right_plus_input_bypass_o <= bypass_q[CMPR_BYP_R2P_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // dac current adjustment
  // ----------------------------------------------------------------------------
  logic [1:0] dac_code;

  // stored as written so a read shows what the host wrote
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dac_cur_q <= CMPR_DAC_CUR_RST;
    end
    else if (wr_stb && hit_dac)
    begin
      dac_cur_q <= wb_dat_i[7:0];
    end
  end

  assign dac_code = dac_cur_q[CMPR_DAC_CUR_LSB +: 2];

  // reserved code falls back to default
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dac_current_boost_o <= CMPR_DAC_CUR_DEFAULT;
    end
    else if (dac_code == CMPR_DAC_CUR_RESERVED)
    begin
      dac_current_boost_o <= CMPR_DAC_CUR_DEFAULT;
    end
    else
    begin
      dac_current_boost_o <= dac_code;
    end
  end

  // ----------------------------------------------------------------------------
  // page select
  // ----------------------------------------------------------------------------
  // page bit from bit zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      page_q <= CMPR_PAGE_RST;
    end
    else if (wr_stb && hit_page)
    begin
      page_q <= wb_dat_i[CMPR_PAGE_BIT];
    end
  end

  // follows the page flop by one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active_page_o <= CMPR_PAGE_RST;
    end
    else
    begin
      active_page_o <= page_q;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------------
  logic [CMPR_EVT_W-1:0] evt;

  assign evt[CMPR_EVT_BUS_ERR] = err_event;
  assign evt[CMPR_EVT_BYP_SHORT] = byp_short;

  // status clears on read of its register; a new event in that cycle stays
  cmpr_sticky #(
    .WIDTH(CMPR_EVT_W)
  ) u_irq_stat (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(evt),
    .clr_i(rd_stb && hit_stat),
    .flags_o(irq_stat)
  );

  // mask: a one lets the matching status bit reach the interrupt line
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_mask_q <= CMPR_IRQ_MASK_RST;
    end
    else if (wr_stb && hit_mask)
    begin
      irq_mask_q <= wb_dat_i[CMPR_EVT_W-1:0];
    end
  end

  // registered level, one cycle behind the status bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_stat & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------------------------
  logic [7:0] rd_byte;

  // unmapped indices and the other page read zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_page)
    begin
      rd_byte = {7'h00, page_q};
    end
    else if (hit_adc)
    begin
      rd_byte = {adc_path_q[7:2], 1'b0, bus_err_flag};
    end
    else if (hit_byp)
    begin
      rd_byte = bypass_q;
    end
    else if (hit_dac)
    begin
      rd_byte = dac_cur_q;
    end
    else if (hit_rsvd)
    begin
      rd_byte = CMPR_RSVD_READ;
    end
    else if (hit_stat)
    begin
      rd_byte = {{(8 - CMPR_EVT_W){1'b0}}, irq_stat};
    end
    else if (hit_mask)
    begin
      rd_byte = {{(8 - CMPR_EVT_W){1'b0}}, irq_mask_q};
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= access;
      if (rd_stb)
      begin
        rdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule : cmpr_regs

// *** verilog/cmpr_sticky.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// sticky flag bank: set by hardware, cleared as a group by a read strobe
// ----------------------------------------------------------------------------
module cmpr_sticky
#(
  parameter int unsigned WIDTH = 1
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic clr_i,
  output logic [WIDTH-1:0] flags_o
);

  // a zero-width bank has nothing to hold
  if (WIDTH < 1)
  begin : g_bad_width
    $error("cmpr_sticky: WIDTH must be at least 1");
  end

  // one flop per flag; a set in the clearing cycle survives the clear
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_flag
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        flags_o[i] <= 1'b0;
      end
      else if (set_i[i])
      begin
        flags_o[i] <= 1'b1;
      end
      else if (clr_i)
      begin
        flags_o[i] <= 1'b0;
      end
    end
  end

endmodule : cmpr_sticky
